// ### hw/ocrm_consts.vh
// Purpose: constants for the option card reference and monitor block
// Assumes: included by ocrm_top.v, the port checker and the self-checking bench
// Notes:   selector codes address the plain configuration write port
`ifndef OCRM_CONSTS_VH
`define OCRM_CONSTS_VH
`define OCRM_SEL_COMBINE   4'h0
`define OCRM_SEL_FORMAT    4'h1
`define OCRM_SEL_M1_ITEM   4'h2
`define OCRM_SEL_M1_GAIN   4'h3
`define OCRM_SEL_M2_ITEM   4'h4
`define OCRM_SEL_M2_GAIN   4'h5
`define OCRM_SEL_M1_BIAS   4'h6
`define OCRM_SEL_M2_BIAS   4'h7
`define OCRM_SEL_LEVEL     4'h8
`define OCRM_SEL_DISP      4'h9
`define OCRM_RST_M1_ITEM   6'h02
`define OCRM_RST_M2_ITEM   6'h03
`define OCRM_RST_M1_GAIN   8'h64
`define OCRM_RST_M2_GAIN   8'h32
`define OCRM_GAIN_MAX      8'hfa
`define OCRM_BIAS_MAX      8'h0a
`define OCRM_BIAS_MIN      8'hf6
`define OCRM_ITEM_MAX      6'h26
`define OCRM_ITEM_BAD      64'h0000_000c_f200_6c10
`define OCRM_FMT_SPECIAL   3'h6
`define OCRM_FMT_BINARY    3'h7
`define OCRM_REF_SRC_TERM  2'h1
`define OCRM_DISP_MIN      8'h02
`define OCRM_FS_8BIT       15'h00ff
`define OCRM_FS_12BIT      15'h0fff
`define OCRM_FS_16BIT      15'h7530
`define OCRM_FULL_PCT      29'h0000_2710
`define OCRM_DIV_STEPS     5'h1c
`define OCRM_MON_FULL      34'h0_0000_03e8
`define OCRM_DIV100_MUL    34'h0_0000_051f
`define OCRM_DIV100_SH     17
`endif

// ### hw/ocrm_top.v
// Purpose: option card reference decode and analog monitor output shaping
// Assumes: all inputs synchronous to clk_i; settings arrive on the cfg write port
// Notes:   monitor values and outputs are in 0.1 % of 10 V, signed
`include "ocrm_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module ocrm_top #(
    parameter AIN_W = 14,
    parameter MON_W = 12
) (
    input  wire                    clk_i,
    input  wire                    reset_n_i,
    input  wire                    ce_i,
    input  wire                    running_i,
    input  wire                    cfg_wr_i,
    input  wire [3:0]              cfg_sel_i,
    input  wire [7:0]              cfg_data_i,
    output reg                     cfg_ack_o,
    output reg                     cfg_rej_o,
    input  wire                    ai_card3_i,
    input  wire                    di_card16_i,
    input  wire                    di_bits12_i,
    input  wire                    ao_card12_i,
    input  wire [1:0]              reference_source_select_i,
    input  wire                    mfi_opt_sel_i,
    output reg  [1:0]              cfg_err_o,
    input  wire [AIN_W-1:0]        ain1_i,
    input  wire [AIN_W-1:0]        ain2_i,
    input  wire [AIN_W-1:0]        ain3_i,
    output reg  [AIN_W-1:0]        ain1_o,
    output reg  [AIN_W-1:0]        ain2_o,
    output reg  [AIN_W-1:0]        ain3_o,
    output reg  [AIN_W+1:0]        ain_sum_o,
    input  wire [16:0]             din_i,
    input  wire                    din_stb_i,
    output reg  [16:0]             dig_ref_o,
    output reg                     dig_ref_neg_o,
    output reg  [2:0]              dig_ref_unit_o,
    output reg                     dig_ref_disp_o,
    output reg                     dig_ref_vld_o,
    output reg                     dig_ref_bad_o,
    output wire                    dig_busy_o,
    output reg  [5:0]              mon1_item_o,
    output reg  [5:0]              mon2_item_o,
    input  wire signed [MON_W-1:0] mon1_val_i,
    input  wire signed [MON_W-1:0] mon2_val_i,
    input  wire                    mon1_bip_i,
    input  wire                    mon2_bip_i,
    output reg  [MON_W-1:0]        ao1_o,
    output reg  [MON_W-1:0]        ao2_o
);

////////////////////////////////////////////////////////////////////////////////
localparam S_IDLE = 2'b01;
localparam S_DIV  = 2'b10;

reg        combine_r;
reg  [2:0] format_r;
reg  [7:0] m1_gain_r;
reg  [7:0] m2_gain_r;
reg  [4:0] m1_bias_r;
reg  [4:0] m2_bias_r;
reg        level_r;
reg  [7:0] disp_r;
reg  [1:0] state_r;
reg  [28:0] num_r;
reg  [28:0] quo_r;
reg  [14:0] rem_r;
reg  [14:0] fs_r;
reg  [4:0] cnt_r;

// excluded monitor items as a bit mask, indexed by item number
localparam [63:0] ITEM_BAD = `OCRM_ITEM_BAD;

function bcd_ok;
    input [15:0] d;
    begin
        bcd_ok = (d[15:12] <= 4'h9) && (d[11:8] <= 4'h9) &&
                 (d[7:4] <= 4'h9) && (d[3:0] <= 4'h9);
    end
endfunction

function [16:0] bcd_val;
    input [15:0] d;
    begin
        bcd_val = {13'h0000, d[15:12]} * 17'h003e8 + {13'h0000, d[11:8]} * 17'h00064 +
                  {13'h0000, d[7:4]} * 17'h0000a + {13'h0000, d[3:0]};
    end
endfunction

function item_ok;
    input [5:0] it;
    begin
        item_ok = (it != 6'h00) && (it <= `OCRM_ITEM_MAX) && !ITEM_BAD[it];
    end
endfunction

// divide by 100 as multiply and shift: error stays below one output step
function [MON_W-1:0] mon_calc;
    input signed [MON_W-1:0] v;
    input [7:0]              g;
    input [4:0]              b;
    input                    bip;
    reg signed [33:0]        p;
    begin
        p = v * $signed({1'b0, g});
        p = (p * $signed(`OCRM_DIV100_MUL)) >>> `OCRM_DIV100_SH;
        p = p + $signed(b) * $signed(34'h0_0000_000a);
        if (p > $signed(`OCRM_MON_FULL))
            p = `OCRM_MON_FULL;
        if (bip && (p < -$signed(`OCRM_MON_FULL)))
            p = -$signed(`OCRM_MON_FULL);
        else if (!bip && (p < 0))
            p = 34'h0_0000_0000;
        mon_calc = p[MON_W-1:0];
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// configuration write port
reg wr_ok;
always @*
begin
    case (cfg_sel_i)
        `OCRM_SEL_COMBINE: wr_ok = !running_i && cfg_data_i <= 8'h01;
        `OCRM_SEL_FORMAT:  wr_ok = !running_i && cfg_data_i <= 8'h07 &&
                                   (cfg_data_i[2:0] != `OCRM_FMT_SPECIAL || di_card16_i);
        `OCRM_SEL_M1_ITEM,
        `OCRM_SEL_M2_ITEM: wr_ok = !running_i && cfg_data_i[7:6] == 2'b00 &&
                                   item_ok(cfg_data_i[5:0]);
        `OCRM_SEL_M1_GAIN,
        `OCRM_SEL_M2_GAIN: wr_ok = cfg_data_i <= `OCRM_GAIN_MAX;
        `OCRM_SEL_M1_BIAS,
        `OCRM_SEL_M2_BIAS: wr_ok = $signed(cfg_data_i) <= $signed(`OCRM_BIAS_MAX) &&
                                   $signed(cfg_data_i) >= $signed(`OCRM_BIAS_MIN);
        `OCRM_SEL_LEVEL:   wr_ok = cfg_data_i <= 8'h01;
        `OCRM_SEL_DISP:    wr_ok = 1'b1;
        default:           wr_ok = 1'b0;
    endcase
end

always @(posedge clk_i)
begin
    if (!reset_n_i)
    begin
        combine_r   <= 1'b0;
        format_r    <= 3'h0;
        mon1_item_o <= `OCRM_RST_M1_ITEM;
        mon2_item_o <= `OCRM_RST_M2_ITEM;
        m1_gain_r   <= `OCRM_RST_M1_GAIN;
        m2_gain_r   <= `OCRM_RST_M2_GAIN;
        m1_bias_r   <= 5'h00;
        m2_bias_r   <= 5'h00;
        level_r     <= 1'b0;
        disp_r      <= 8'h00;
        cfg_ack_o   <= 1'b0;
        cfg_rej_o   <= 1'b0;
    end
    else if (ce_i)
    begin
        cfg_ack_o <= cfg_wr_i && wr_ok;
        cfg_rej_o <= cfg_wr_i && !wr_ok;
        if (cfg_wr_i && wr_ok)
        begin
            case (cfg_sel_i)
                `OCRM_SEL_COMBINE: combine_r   <= cfg_data_i[0];
                `OCRM_SEL_FORMAT:  format_r    <= cfg_data_i[2:0];
                `OCRM_SEL_M1_ITEM: mon1_item_o <= cfg_data_i[5:0];
                `OCRM_SEL_M2_ITEM: mon2_item_o <= cfg_data_i[5:0];
                `OCRM_SEL_M1_GAIN: m1_gain_r   <= cfg_data_i;
                `OCRM_SEL_M2_GAIN: m2_gain_r   <= cfg_data_i;
                `OCRM_SEL_M1_BIAS: m1_bias_r   <= cfg_data_i[4:0];
                `OCRM_SEL_M2_BIAS: m2_bias_r   <= cfg_data_i[4:0];
                `OCRM_SEL_LEVEL:   level_r     <= cfg_data_i[0];
                `OCRM_SEL_DISP:    disp_r      <= cfg_data_i;
                default:           level_r     <= level_r;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// analog reference card and configuration checks
always @(posedge clk_i)
begin
    if (!reset_n_i)
    begin
        ain1_o    <= {AIN_W{1'b0}};
        ain2_o    <= {AIN_W{1'b0}};
        ain3_o    <= {AIN_W{1'b0}};
        ain_sum_o <= {(AIN_W+2){1'b0}};
        cfg_err_o <= 2'b00;
    end
    else if (ce_i)
    begin
        if (combine_r)
        begin
            ain_sum_o <= {2'b00, ain1_i} + {2'b00, ain2_i} + {2'b00, ain3_i};
            ain1_o    <= {AIN_W{1'b0}};
            ain2_o    <= {AIN_W{1'b0}};
            ain3_o    <= {AIN_W{1'b0}};
        end
        else
        begin
            ain_sum_o <= {(AIN_W+2){1'b0}};
            ain1_o    <= ain1_i;
            ain2_o    <= ain2_i;
            ain3_o    <= ain3_i;
        end
        // source setting itself is software's job; this only reports a mismatch
        cfg_err_o[0] <= ai_card3_i && combine_r &&
                        reference_source_select_i != `OCRM_REF_SRC_TERM;
        cfg_err_o[1] <= ai_card3_i && mfi_opt_sel_i;
    end
end

////////////////////////////////////////////////////////////////////////////////
// digital reference decode
wire       use_disp = disp_r >= `OCRM_DISP_MIN && format_r != `OCRM_FMT_BINARY;
wire       special  = format_r == `OCRM_FMT_SPECIAL && !use_disp;
wire       binary   = format_r == `OCRM_FMT_BINARY;
wire [3:0] low_dig  = (din_i[2:0] >= 3'h5) ? 4'h9 : {din_i[2:0], 1'b0};
wire [15:0] sp_dig  = {din_i[14:3], low_dig};
wire [15:0] nm_dig  = di_card16_i ? din_i[15:0] : {8'h00, din_i[7:0]};
wire [16:0] sp_val  = {15'h0000, din_i[16:15]} * 17'h02710 + bcd_val(sp_dig);
wire [14:0] fs_sel  = !di_card16_i ? `OCRM_FS_8BIT :
                      (di_bits12_i ? `OCRM_FS_12BIT : `OCRM_FS_16BIT);
wire [15:0] bin_raw = !di_card16_i ? {8'h00, din_i[7:0]} :
                      (di_bits12_i ? {4'h0, din_i[11:0]} : din_i[15:0]);
wire [14:0] bin_val = (bin_raw > {1'b0, fs_sel}) ? fs_sel : bin_raw[14:0];
wire [15:0] rem_sh  = {rem_r, num_r[28]};
wire        sub_ok  = rem_sh >= {1'b0, fs_r};
wire        go      = ce_i && din_stb_i && state_r == S_IDLE;

assign dig_busy_o = state_r != S_IDLE;

always @(posedge clk_i)
begin
    if (!reset_n_i)
    begin
        state_r        <= S_IDLE;
        num_r          <= 29'h0000_0000;
        quo_r          <= 29'h0000_0000;
        rem_r          <= 15'h0000;
        fs_r           <= 15'h0000;
        cnt_r          <= 5'h00;
        dig_ref_o      <= 17'h00000;
        dig_ref_neg_o  <= 1'b0;
        dig_ref_unit_o <= 3'h0;
        dig_ref_disp_o <= 1'b0;
        dig_ref_vld_o  <= 1'b0;
        dig_ref_bad_o  <= 1'b0;
    end
    else if (ce_i)
    begin
        dig_ref_vld_o <= 1'b0;
        dig_ref_bad_o <= 1'b0;
        case (state_r)
            S_IDLE:
            begin
                if (go && binary)
                begin
                    // binary full scale maps to 100.00 %, divided one bit per cycle
                    num_r   <= {14'h0000, bin_val} * `OCRM_FULL_PCT;
                    fs_r    <= fs_sel;
                    rem_r   <= 15'h0000;
                    quo_r   <= 29'h0000_0000;
                    cnt_r   <= 5'h00;
                    state_r <= S_DIV;
                end
                else if (go && special && (!di_card16_i || !bcd_ok({din_i[14:3], 4'h0})))
                    dig_ref_bad_o <= 1'b1;
                else if (go && special)
                begin
                    dig_ref_o      <= sp_val;
                    dig_ref_neg_o  <= 1'b0;
                    dig_ref_unit_o <= format_r;
                    dig_ref_disp_o <= 1'b0;
                    dig_ref_vld_o  <= 1'b1;
                end
                else if (go && !bcd_ok(nm_dig))
                    dig_ref_bad_o <= 1'b1;
                else if (go)
                begin
                    dig_ref_o      <= bcd_val(nm_dig);
                    dig_ref_neg_o  <= di_card16_i && din_i[16];
                    dig_ref_unit_o <= format_r;
                    dig_ref_disp_o <= use_disp;
                    dig_ref_vld_o  <= 1'b1;
                end
            end
            S_DIV:
            begin
                rem_r <= sub_ok ? rem_sh[14:0] - fs_r : rem_sh[14:0];
                quo_r <= {quo_r[27:0], sub_ok};
                num_r <= {num_r[27:0], 1'b0};
                cnt_r <= cnt_r + 5'h01;
                if (cnt_r == `OCRM_DIV_STEPS)
                begin
                    dig_ref_o      <= {quo_r[15:0], sub_ok};
                    dig_ref_neg_o  <= 1'b0;
                    dig_ref_unit_o <= format_r;
                    dig_ref_disp_o <= 1'b0;
                    dig_ref_vld_o  <= 1'b1;
                    state_r        <= S_IDLE;
                end
            end
            default: state_r <= S_IDLE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// analog monitor outputs
always @(posedge clk_i)
begin
    if (!reset_n_i)
    begin
        ao1_o <= {MON_W{1'b0}};
        ao2_o <= {MON_W{1'b0}};
    end
    else if (ce_i)
    begin
        ao1_o <= mon_calc(mon1_val_i, m1_gain_r, m1_bias_r,
                          level_r && ao_card12_i && mon1_bip_i);
        ao2_o <= mon_calc(mon2_val_i, m2_gain_r, m2_bias_r,
                          level_r && ao_card12_i && mon2_bip_i);
    end
end

endmodule // ocrm_top
`default_nettype wire

// ### bench/ocrm_props_properties.sv
// Purpose: port-level checker for the option card reference and monitor block
// Assumes: sees only top ports; one clock domain
// Notes:   bound to every ocrm_top instance below
`include "ocrm_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module ocrm_props #(
    parameter AIN_W = 14,
    parameter MON_W = 12
) (
    input wire logic             clk_i,
    input wire logic             reset_n_i,
    input wire logic             ce_i,
    input wire logic             running_i,
    input wire logic             cfg_wr_i,
    input wire logic [3:0]       cfg_sel_i,
    input wire logic [7:0]       cfg_data_i,
    input wire logic             cfg_ack_o,
    input wire logic             cfg_rej_o,
    input wire logic             ai_card3_i,
    input wire logic             di_card16_i,
    input wire logic             ao_card12_i,
    input wire logic             mfi_opt_sel_i,
    input wire logic [1:0]       cfg_err_o,
    input wire logic [AIN_W-1:0] ain1_o,
    input wire logic [AIN_W-1:0] ain2_o,
    input wire logic [AIN_W-1:0] ain3_o,
    input wire logic [AIN_W+1:0] ain_sum_o,
    input wire logic             dig_busy_o,
    input wire logic             dig_ref_vld_o,
    input wire logic [MON_W-1:0] ao1_o,
    input wire logic [MON_W-1:0] ao2_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i || !ce_i);
    wire gain_sel = cfg_sel_i == `OCRM_SEL_M1_GAIN || cfg_sel_i == `OCRM_SEL_M2_GAIN;
    wire item_sel = cfg_sel_i == `OCRM_SEL_M1_ITEM || cfg_sel_i == `OCRM_SEL_M2_ITEM;
    ////////////////////////////////////////////////////////////////////////////
    sequence s_div_run;
        dig_busy_o throughout (##28 1'b1);
    endsequence
    sequence s_div_end;
        dig_ref_vld_o && !dig_busy_o;
    endsequence
    property p_lock_run;
        cfg_wr_i && running_i && (cfg_sel_i <= 4'h1 || item_sel) |=> cfg_rej_o && !cfg_ack_o;
    endproperty
    a_lock_run: assert property (p_lock_run) else $error("locked setting taken while running");
    property p_gain_run;
        cfg_wr_i && running_i && gain_sel && cfg_data_i <= `OCRM_GAIN_MAX |=> cfg_ack_o;
    endproperty
    a_gain_run: assert property (p_gain_run) else $error("gain write refused");
    property p_gain_max;
        cfg_wr_i && gain_sel && cfg_data_i > `OCRM_GAIN_MAX |=> cfg_rej_o;
    endproperty
    a_gain_max: assert property (p_gain_max) else $error("gain above 2.50 taken");
    property p_item_bad;
        cfg_wr_i && item_sel && cfg_data_i inside {8'h00, 8'h04, 8'h0a, 8'h0b, 8'h0d, 8'h0e,
            8'h19, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h22, 8'h23, [8'h27:8'hff]} |=> cfg_rej_o;
    endproperty
    a_item_bad: assert property (p_item_bad) else $error("excluded monitor item taken");
    property p_fmt6;
        cfg_wr_i && cfg_sel_i == `OCRM_SEL_FORMAT && cfg_data_i == 8'h06 && !di_card16_i
            |=> cfg_rej_o;
    endproperty
    a_fmt6: assert property (p_fmt6) else $error("special format taken without wide card");
    property p_combine_split;
        ain_sum_o != 0 |-> ain1_o == 0 && ain2_o == 0 && ain3_o == 0;
    endproperty
    a_combine_split: assert property (p_combine_split) else $error("sum and split both live");
    property p_opt_sel;
        ai_card3_i && mfi_opt_sel_i |=> cfg_err_o[1];
    endproperty
    a_opt_sel: assert property (p_opt_sel) else $error("option select not flagged");
    property p_unipolar;
        !ao_card12_i |=> !ao1_o[MON_W-1] && !ao2_o[MON_W-1];
    endproperty
    a_unipolar: assert property (p_unipolar) else $error("negative output on narrow card");
    property p_div;
        $rose(dig_busy_o) |-> s_div_run ##1 s_div_end;
    endproperty
    a_div: assert property (p_div) else $error("binary result timing wrong");
endmodule // ocrm_props
bind ocrm_top ocrm_props #(.AIN_W(AIN_W), .MON_W(MON_W)) u_props (.*);
`default_nettype wire

// ### bench/ocrm_cards.sv
// Purpose: model of the plug-in reference and monitor cards
// Assumes: card outputs settle one clock after the bench sets them
// Notes:   analog channels hold fixed distinct levels
`timescale 1ns/10ps
`default_nettype none
module ocrm_cards (
    input  wire logic               clk_i,
    input  wire logic [16:0]        din_set_i,
    input  wire logic signed [11:0] mval_i,
    output logic [13:0]             ain1_o,
    output logic [13:0]             ain2_o,
    output logic [13:0]             ain3_o,
    output logic [16:0]             din_o,
    output logic signed [11:0]      mon1_o,
    output logic signed [11:0]      mon2_o,
    output logic                    bip1_o,
    output logic                    bip2_o,
    output logic [1:0]              ref_src_o
);
    assign ain1_o = 14'h0123;
    assign ain2_o = 14'h0456;
    assign ain3_o = 14'h0789;
    assign bip1_o = 1'b1;
    // channel two item stays unipolar to exercise the exception
    assign bip2_o = 1'b0;
    assign ref_src_o = 2'h3;
    always @(posedge clk_i)
    begin
        din_o <= din_set_i;
        mon1_o <= mval_i;
        mon2_o <= mval_i;
    end
endmodule // ocrm_cards
`default_nettype wire

// ### bench/option_card_reference_monitor_tb.sv
// Purpose: self-checking bench for the option card block
// Assumes: 250 MHz clock, ce_i held high
// Notes:   each scenario task drives and judges on its own
`include "ocrm_consts.vh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module option_card_reference_monitor_tb;
    reg clk_i = 0, reset_n_i = 0, running_i = 0, cfg_wr_i = 0, ai_card3_i = 0, din_stb_i = 0;
    reg di_card16_i = 0, di_bits12_i = 0, ao_card12_i = 0, mfi_opt_sel_i = 0;
    reg [3:0] cfg_sel_i = 0;
    reg [7:0] cfg_data_i = 0;
    reg [16:0] din_set = 0;
    reg signed [11:0] mval = 0;
    wire ack, rej, busy, vld, bad, neg, disp, bip1, bip2;
    wire [1:0] err, rsrc;
    wire [13:0] a1, a2, a3, a1o, a2o, a3o;
    wire [15:0] sum;
    wire [16:0] din, dref;
    wire [2:0] unit;
    wire [5:0] m1, m2;
    wire [11:0] mv1, mv2, ao1, ao2;
    int n_errors = 0, checks_done = 0, cyc = 0;
    int bad_items[12] = '{4, 10, 11, 13, 14, 25, 28, 29, 30, 31, 34, 35};
    ocrm_cards u_cards (.clk_i(clk_i), .din_set_i(din_set), .mval_i(mval), .ain1_o(a1),
        .ain2_o(a2), .ain3_o(a3), .din_o(din), .mon1_o(mv1), .mon2_o(mv2), .bip1_o(bip1),
        .bip2_o(bip2), .ref_src_o(rsrc));
    ocrm_top DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1), .running_i(running_i),
        .cfg_wr_i(cfg_wr_i), .cfg_sel_i(cfg_sel_i), .cfg_data_i(cfg_data_i), .cfg_ack_o(ack),
        .cfg_rej_o(rej), .ai_card3_i(ai_card3_i), .di_card16_i(di_card16_i),
        .di_bits12_i(di_bits12_i), .ao_card12_i(ao_card12_i), .reference_source_select_i(rsrc),
        .mfi_opt_sel_i(mfi_opt_sel_i), .cfg_err_o(err), .ain1_i(a1), .ain2_i(a2), .ain3_i(a3),
        .ain1_o(a1o), .ain2_o(a2o), .ain3_o(a3o), .ain_sum_o(sum), .din_i(din),
        .din_stb_i(din_stb_i), .dig_ref_o(dref), .dig_ref_neg_o(neg), .dig_ref_unit_o(unit),
        .dig_ref_disp_o(disp), .dig_ref_vld_o(vld), .dig_ref_bad_o(bad), .dig_busy_o(busy),
        .mon1_item_o(m1), .mon2_item_o(m2), .mon1_val_i(mv1), .mon2_val_i(mv2),
        .mon1_bip_i(bip1), .mon2_bip_i(bip2), .ao1_o(ao1), .ao2_o(ao2));
    initial forever #2 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////////
    task close_out;
        if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            close_out;
        end
    end
    task wr(input r, input [3:0] s, input [7:0] d, input ok);
        @(posedge clk_i);
        running_i <= r;
        cfg_sel_i <= s;
        cfg_data_i <= d;
        cfg_wr_i <= 1;
        @(posedge clk_i);
        cfg_wr_i <= 0;
        #1;
        `CHK("ack", ok, ack)
        `CHK("rej", !ok, rej)
    endtask
    // binary samples take 29 divide cycles, so the wait allows 40
    task smp(input [16:0] d, input [16:0] e, input b);
        int i;
        i = 0;
        @(posedge clk_i);
        din_set <= d;
        repeat (2) @(posedge clk_i);
        din_stb_i <= 1;
        @(posedge clk_i);
        din_stb_i <= 0;
        #1;
        while (i < 40 && vld !== 1'b1 && bad !== 1'b1)
        begin
            @(posedge clk_i);
            #1;
            i++;
        end
        `CHK("bad", b, bad)
        `CHK("vld", !b, vld)
        if (!b) `CHK("ref", e, dref)
    endtask
    task mon(input signed [11:0] v, input signed [11:0] e1, input signed [11:0] e2);
        @(posedge clk_i);
        mval <= v;
        repeat (3) @(posedge clk_i);
        #1;
        `CHK("ao1", e1, ao1)
        `CHK("ao2", e2, ao2)
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task t_cfg;
        `CHK("item1", 6'h02, m1)
        `CHK("item2", 6'h03, m2)
        mon(500, 500, 250);
        wr(1, `OCRM_SEL_COMBINE, 1, 0);
        wr(1, `OCRM_SEL_FORMAT, 2, 0);
        wr(1, `OCRM_SEL_M1_ITEM, 5, 0);
        wr(1, `OCRM_SEL_M1_GAIN, 8'hfa, 1);
        wr(0, `OCRM_SEL_M1_GAIN, 8'hfb, 0);
        wr(0, `OCRM_SEL_M1_BIAS, 8'hf5, 0);
        wr(0, `OCRM_SEL_COMBINE, 2, 0);
        wr(0, `OCRM_SEL_FORMAT, 6, 0);
        wr(0, `OCRM_SEL_M2_ITEM, 8'h27, 0);
        foreach (bad_items[k]) wr(0, `OCRM_SEL_M2_ITEM, bad_items[k], 0);
        wr(0, `OCRM_SEL_M2_ITEM, 8'h26, 1);
        `CHK("item2", 6'h26, m2)
    endtask
    task t_ain;
        ai_card3_i <= 1;
        `CHK("ain1", 14'h0123, a1o)
        `CHK("ain2", 14'h0456, a2o)
        `CHK("sum", 16'h0000, sum)
        wr(0, `OCRM_SEL_COMBINE, 1, 1);
        mfi_opt_sel_i <= 1;
        repeat (2) @(posedge clk_i);
        #1;
        `CHK("sum", 16'h0d02, sum)
        `CHK("ain3", 14'h0000, a3o)
        `CHK("err", 2'h3, err)
        mfi_opt_sel_i <= 0;
        wr(0, `OCRM_SEL_COMBINE, 0, 1);
        repeat (2) @(posedge clk_i);
        #1;
        `CHK("err", 2'h0, err)
    endtask
    task t_dig;
        di_card16_i <= 1;
        for (int f = 0; f < 6; f++)
        begin
            wr(0, `OCRM_SEL_FORMAT, f, 1);
            smp(17'h01234, 1234, 0);
            `CHK("unit", f[2:0], unit)
        end
        smp(17'h000a0, 0, 1);
        wr(0, `OCRM_SEL_FORMAT, 6, 1);
        smp({2'b10, 12'h123, 3'b111}, 21239, 0);
        `CHK("neg", 1'b0, neg)
        smp({2'b01, 12'h045, 3'b101}, 10459, 0);
        smp({2'b00, 12'h000, 3'b011}, 6, 0);
        smp({2'b00, 12'h0a0, 3'b000}, 0, 1);
        wr(0, `OCRM_SEL_DISP, 2, 1);
        smp(17'h01234, 1234, 0);
        `CHK("disp", 1'b1, disp)
        wr(0, `OCRM_SEL_FORMAT, 7, 1);
        smp(17'h0ffff, 10000, 0);
        di_bits12_i <= 1;
        smp(17'h00fff, 10000, 0);
        di_bits12_i <= 0;
        smp(17'h07530, 10000, 0);
        smp(17'h03a98, 5000, 0);
        di_card16_i <= 0;
        smp(17'h000ff, 10000, 0);
        smp(17'h00080, 5019, 0);
    endtask
    task t_mon;
        ao_card12_i <= 1;
        wr(0, `OCRM_SEL_LEVEL, 1, 1);
        wr(1, `OCRM_SEL_M1_BIAS, 8'hf6, 1);
        wr(1, `OCRM_SEL_M2_BIAS, 8'hf6, 1);
        wr(1, `OCRM_SEL_M1_GAIN, 8'h64, 1);
        mon(0, -100, 0);
        ao_card12_i <= 0;
        mon(0, 0, 0);
        wr(0, `OCRM_SEL_M1_BIAS, 8'h0a, 1);
        mon(500, 600, 150);
    endtask
    initial
    begin
        repeat (5) @(posedge clk_i);
        reset_n_i <= 1;
        @(posedge clk_i);
        #1;
        t_cfg;
        t_ain;
        t_dig;
        t_mon;
        close_out;
    end
endmodule // option_card_reference_monitor_tb
`default_nettype wire
